// ===== rtl/csu_slave.sv
// Serial unit, slave end: control registers, shift engine, irq pulses
// How it works
// - 07H to control two: type 1, external clock
// - 00H to length register: 8-bit words
// - A3H to control one: continuous receive-only
// - E3H to control one: continuous transmit/receive
// - Receive-only: dummy receive read sets busy
// - Transmit write sets busy flag
// - Drive output, sample input on serial clock
// - Word done: rx irq, data readable
// - Continuous rx enable restarts next reception
// - Clearing continuous enable ends after current word
// - Tx irq when buffer moves to shifter
// - New tx word continues without gap
// - No new tx word: rx irq, busy clears
// - Continuous mode: unread word overwritten: irq, overrun flag set
// - Software writes zero to clear overrun
// - Software reads before next last bit
// - Software checks idle before disabling
// - Tx irq only in continuous mode
// - Single mode: rx irq after every transfer
// - Single mode: tx write while busy dropped
// - Otherwise rx irq needs receive enabled
// - Phase-one types clear busy half clock later
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "csu_regs.svh"
module csu_slave
  import csu_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic rx_complete_irq,
  output logic tx_enable_irq,
  csu_if.device link
);
  logic [7:0] serial_control_first_q;
  logic [7:0] serial_control_second_q;
  logic [3:0] serial_word_length_reg_q;
  logic transfer_in_progress_flag_q;
  logic overrun_flag_q;
  logic active_q, end_pend_q, tx_full_q, unread_q, sck_prev_q, so_q;
  logic [15:0] rdata_q;
  csu_len_t cnt_q;
  csu_word_t transmit_data_reg_q;
  csu_word_t tx_sh_q;
  csu_word_t rx_sh_q;
  csu_word_t receive_data_reg_q;
  logic sck_s, sdi_s;
  csu_sync #(.W(2)) u_sync (.core_clk(core_clk), .resetn(resetn), .d({link.sck, link.sdi}),
    .q({sck_s, sdi_s}));
  wire interface_power_enable = serial_control_first_q[`CSU_CTL0_PWR];
  wire transmit_enable_bit = serial_control_first_q[`CSU_CTL0_TXE];
  wire receive_enable_bit = serial_control_first_q[`CSU_CTL0_RXE];
  wire bit_order_select = serial_control_first_q[`CSU_CTL0_DIR];
  wire continuous_mode = serial_control_first_q[`CSU_CTL0_TMS];
  wire continuous_rx_enable = serial_control_first_q[`CSU_CTL0_SCE];
  wire clock_polarity_select = serial_control_second_q[`CSU_CTL1_CKP];
  wire data_phase_select = serial_control_second_q[`CSU_CTL1_DAP];
  wire [2:0] clock_source_select = serial_control_second_q[`CSU_CTL1_CKS];
  wire link_on = interface_power_enable && (clock_source_select == `CSU_CKS_EXT);
  wire rise = sck_s && !sck_prev_q;
  wire fall = !sck_s && sck_prev_q;
  wire swap_edges = clock_polarity_select ^ data_phase_select;
  wire sample_edge = link_on && (swap_edges ? fall : rise);
  wire drive_edge = link_on && (swap_edges ? rise : fall);
  wire csu_len_t len = csu_word_len(serial_word_length_reg_q);
  wire csu_word_t word_mask = 16'((17'h00001 << len) - 17'h00001);
  wire wr_tx = reg_wr && (reg_addr == `CSU_ADDR_TX);
  wire rd_rx = reg_rd && (reg_addr == `CSU_ADDR_RX);
  wire wr_stat = reg_wr && (reg_addr == `CSU_ADDR_STAT);
  // single-mode writes while busy are dropped
  wire tx_accept = wr_tx && interface_power_enable && transmit_enable_bit
                   && (continuous_mode || !transfer_in_progress_flag_q);
  // dummy read starts reception, not once continuous ended
  wire rx_start = rd_rx && interface_power_enable && receive_enable_bit && !transmit_enable_bit
                  && !transfer_in_progress_flag_q && (continuous_rx_enable || !continuous_mode);
  wire load_idle = interface_power_enable && transmit_enable_bit && transfer_in_progress_flag_q
                   && !active_q && tx_full_q && !end_pend_q;
  // word ends only at the configured count
  wire done = active_q && sample_edge && (cnt_q == len - 5'h01);
  // next word follows with no gap
  wire load_cont = done && transmit_enable_bit && continuous_mode && tx_full_q;
  wire rx_cont = done && !transmit_enable_bit && continuous_mode && continuous_rx_enable;
  // word ends with nothing more to do
  wire done_end = done && !load_cont && !rx_cont;
  wire load = load_idle || load_cont;
  wire csu_word_t rx_next = csu_rx_shift(rx_sh_q, sdi_s, len, bit_order_select);
  wire rx_enabled_done = done && receive_enable_bit;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      serial_control_first_q <= `CSU_CTL0_RST;
      serial_control_second_q <= `CSU_CTL1_RST;
      serial_word_length_reg_q <= `CSU_CTL2_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `CSU_ADDR_CTL0)
        serial_control_first_q <= reg_wdata[7:0];
      if (reg_addr == `CSU_ADDR_CTL1)
        serial_control_second_q <= reg_wdata[7:0];
      if (reg_addr == `CSU_ADDR_CTL2)
        serial_word_length_reg_q <= reg_wdata[`CSU_CTL2_CL];
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 16'h0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `CSU_ADDR_CTL0: rdata_q <= {8'h00, serial_control_first_q};
        `CSU_ADDR_CTL1: rdata_q <= {8'h00, serial_control_second_q};
        `CSU_ADDR_CTL2: rdata_q <= {12'h000, serial_word_length_reg_q};
        `CSU_ADDR_STAT: rdata_q <= {8'h00, transfer_in_progress_flag_q, 6'h00, overrun_flag_q};
        `CSU_ADDR_RX: rdata_q <= receive_data_reg_q;
        default: rdata_q <= 16'h0000;
      endcase
    end
  end
  assign reg_rdata = rdata_q;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      transfer_in_progress_flag_q <= 1'b0;
      end_pend_q <= 1'b0;
    end
    else
    begin
      if (done_end && data_phase_select)
        end_pend_q <= 1'b1;
      else if (drive_edge || !interface_power_enable)
        end_pend_q <= 1'b0;
      if (tx_accept || rx_start)
        transfer_in_progress_flag_q <= 1'b1;
      // busy clears with the last sample edge (next drive edge for phase-one types) or power off
      else if (!interface_power_enable || (done_end && !data_phase_select))
        transfer_in_progress_flag_q <= 1'b0;
      else if (end_pend_q && drive_edge)
        transfer_in_progress_flag_q <= 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      active_q <= 1'b0;
      cnt_q <= 5'h00;
    end
    else if (done || !interface_power_enable)
    begin
      active_q <= load_cont || rx_cont;
      cnt_q <= 5'h00;
    end
    else if (load_idle || rx_start)
    begin
      active_q <= 1'b1;
      cnt_q <= 5'h00;
    end
    else if (active_q && sample_edge)
      cnt_q <= cnt_q + 5'h01;
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      transmit_data_reg_q <= 16'h0000;
      tx_full_q <= 1'b0;
    end
    else if (tx_accept)
    begin
      transmit_data_reg_q <= reg_wdata & word_mask;
      tx_full_q <= 1'b1;
    end
    else if (load || !interface_power_enable)
      tx_full_q <= 1'b0;
  end
  // output shifts on the drive edge
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_sh_q <= 16'h0000;
      so_q <= 1'b0;
    end
    else if (!transmit_enable_bit)
      so_q <= 1'b0;
    else if (load)
    begin
      tx_sh_q <= transmit_data_reg_q;
      so_q <= csu_out_bit(transmit_data_reg_q, len, bit_order_select);
    end
    else if (active_q && drive_edge && (cnt_q != 5'h00))
    begin
      tx_sh_q <= csu_tx_shift(tx_sh_q, bit_order_select);
      so_q <= csu_out_bit(csu_tx_shift(tx_sh_q, bit_order_select), len, bit_order_select);
    end
  end
  assign link.sdo = so_q;

  // input sampled on the sample edge
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_sh_q <= 16'h0000;
      receive_data_reg_q <= 16'h0000;
    end
    else
    begin
      if (active_q && sample_edge)
        rx_sh_q <= rx_next;
      if (rx_enabled_done)
        receive_data_reg_q <= rx_next & word_mask;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      unread_q <= 1'b0;
      overrun_flag_q <= 1'b0;
    end
    else
    begin
      if (rx_enabled_done)
        unread_q <= 1'b1;
      else if (rd_rx || !interface_power_enable)
        unread_q <= 1'b0;
      if (rx_enabled_done && continuous_mode && unread_q)
        overrun_flag_q <= 1'b1;
      else if (wr_stat && !reg_wdata[`CSU_STAT_OVE])
        overrun_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_prev_q <= 1'b0;
      rx_complete_irq <= 1'b0;
      tx_enable_irq <= 1'b0;
    end
    else
    begin
      sck_prev_q <= sck_s;
      rx_complete_irq <= done && (receive_enable_bit || !continuous_mode);
      // tx irq only in continuous mode
      tx_enable_irq <= load && continuous_mode;
    end
  end
endmodule : csu_slave

// ===== pkg/csu_regs.svh
// Register map, field positions, reset values and timing for the clocked serial unit
`ifndef CSU_REGS_SVH
`define CSU_REGS_SVH
`define CSU_ADDR_CTL0 3'h0
`define CSU_ADDR_CTL1 3'h1
`define CSU_ADDR_CTL2 3'h2
`define CSU_ADDR_STAT 3'h3
`define CSU_ADDR_RX 3'h4
`define CSU_ADDR_TX 3'h5
`define CSU_CTL0_PWR 7
`define CSU_CTL0_TXE 6
`define CSU_CTL0_RXE 5
`define CSU_CTL0_DIR 4
`define CSU_CTL0_TMS 1
`define CSU_CTL0_SCE 0
`define CSU_CTL1_CKP 4
`define CSU_CTL1_DAP 3
`define CSU_CTL1_CKS 2:0
`define CSU_CTL2_CL 3:0
`define CSU_STAT_TSF 7
`define CSU_STAT_OVE 0
`define CSU_CKS_EXT 3'h7
`define CSU_CTL0_RST 8'h00
`define CSU_CTL1_RST 8'h00
`define CSU_CTL2_RST 4'h0
`define CSU_BASE_LEN 5'h08
`define CSU_MAX_LEN 5'h10
`define CSU_CL_MAX 4'h8
`define CSU_CLK_NS 100
`define CSU_SCK_HALF_NS 400
`endif

// ===== pkg/csu_pkg.sv
// Types and shared helpers of the clocked serial unit
package csu_pkg;
`include "csu_regs.svh"

  typedef enum logic [1:0] {
    CSU_M_IDLE = 2'b00,
    CSU_M_LOW = 2'b01,
    CSU_M_HIGH = 2'b10
  } csu_mst_state_e;

  typedef logic [4:0] csu_len_t;
  typedef logic [15:0] csu_word_t;

  // Word length from the length field; codes above the maximum clamp
  function automatic csu_len_t csu_word_len(input logic [3:0] cl);
    csu_len_t r;
    r = (cl > `CSU_CL_MAX) ? `CSU_MAX_LEN : `CSU_BASE_LEN + {1'b0, cl};
    return r;
  endfunction : csu_word_len

  // Bit presented on the serial output for the given shifter contents
  function automatic logic csu_out_bit(input csu_word_t sh, input csu_len_t len,
                                       input logic lsb_first);
    logic b;
    b = lsb_first ? sh[0] : sh[4'(len - 5'h01)];
    return b;
  endfunction : csu_out_bit

  function automatic csu_word_t csu_tx_shift(input csu_word_t sh, input logic lsb_first);
    csu_word_t r;
    r = lsb_first ? (sh >> 1) : (sh << 1);
    return r;
  endfunction : csu_tx_shift

  function automatic csu_word_t csu_rx_shift(input csu_word_t sh, input logic b,
                                             input csu_len_t len, input logic lsb_first);
    csu_word_t r;
    r = {sh[14:0], b};
    if (lsb_first)
    begin
      r = sh >> 1;
      r[4'(len - 5'h01)] = b;
    end
    return r;
  endfunction : csu_rx_shift
endpackage : csu_pkg

// ===== pkg/csu_if.sv
// Serial link between the external master and the serial unit
`timescale 1ns/1ps
interface csu_if;
  logic sck;
  logic sdi;
  logic sdo;
  modport device (
    input sck,
    input sdi,
    output sdo
  );
  modport master (
    output sck,
    output sdi,
    input sdo
  );
endinterface : csu_if

// ===== rtl/csu_sync.sv
// Two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/1ps
module csu_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : csu_sync

// ===== rtl/csu_master.sv
// External serial master end: makes the serial clock, type 1, MSB first
`timescale 1ns/1ps
`include "csu_regs.svh"
module csu_master
  import csu_pkg::*;
#(
  parameter int HALF = `CSU_SCK_HALF_NS / `CSU_CLK_NS,
  parameter int WL = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic cont,
  input wire logic [WL-1:0] tx_word,
  output logic busy,
  output logic done,
  output logic [WL-1:0] rx_word,
  csu_if.master link
);
  csu_mst_state_e st_q;
  logic [15:0] div_q;
  logic [7:0] bits_q;
  logic [WL-1:0] sh_q;
  logic [WL-1:0] rx_sh_q;
  logic sck_q;
  logic sdi_q;
  logic sdo_s;

  csu_sync #(.W(1)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .d(link.sdo),
    .q(sdo_s)
  );

  wire half_done = (div_q == 16'(HALF - 1));
  // Sample mid high phase: after the slave's drive change, before its reload
  wire sample_pt = (st_q == CSU_M_HIGH) && (div_q == 16'(HALF / 2)) && (bits_q != 8'h00);
  wire [WL-1:0] rx_next = sample_pt ? {rx_sh_q[WL-2:0], sdo_s} : rx_sh_q;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= CSU_M_IDLE;
      div_q <= 16'h0000;
      bits_q <= 8'h00;
      sh_q <= '0;
      rx_sh_q <= '0;
      rx_word <= '0;
      sck_q <= 1'b1;
      sdi_q <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      rx_sh_q <= rx_next;
      div_q <= half_done ? 16'h0000 : div_q + 16'h0001;
      unique case (st_q)
        CSU_M_IDLE:
        begin
          sck_q <= 1'b1;
          div_q <= 16'h0000;
          if (start)
          begin
            st_q <= CSU_M_HIGH;
            sh_q <= tx_word;
            sdi_q <= tx_word[WL-1];
            bits_q <= 8'h00;
          end
        end
        CSU_M_LOW:
          if (half_done)
          begin
            sck_q <= 1'b1;
            bits_q <= bits_q + 8'h01;
            st_q <= CSU_M_HIGH;
          end
        CSU_M_HIGH:
          if (half_done)
          begin
            sck_q <= 1'b0;
            if (bits_q == 8'(WL))
            begin
              rx_word <= rx_next;
              done <= 1'b1;
              bits_q <= 8'h00;
              sh_q <= tx_word;
              sdi_q <= tx_word[WL-1];
              st_q <= cont ? CSU_M_LOW : CSU_M_IDLE;
              if (!cont)
                sck_q <= 1'b1;
            end
            else
            begin
              st_q <= CSU_M_LOW;
              if (bits_q != 8'h00)
              begin
                sh_q <= {sh_q[WL-2:0], 1'b0};
                sdi_q <= sh_q[WL-2];
              end
            end
          end
        default: st_q <= CSU_M_IDLE;
      endcase
    end
  end

  assign busy = (st_q != CSU_M_IDLE);
  assign link.sck = sck_q;
  assign link.sdi = sdi_q;
endmodule : csu_master

// ===== tb/csu_props.sv
// Checker for the serial link between the master and slave ends
`timescale 1ns/1ps
module csu_props (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic busy,
  input wire logic done,
  input wire logic rx_complete_irq,
  input wire logic tx_enable_irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  logic sck_q;
  logic [3:0] rise_q;

  // Counts serial clock rises within the current word
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_q <= 1'b1;
      rise_q <= 4'h0;
    end
    else
    begin
      sck_q <= sck;
      if (done)
        rise_q <= 4'h0;
      else if (sck && !sck_q)
        rise_q <= rise_q + 4'h1;
    end
  end

  a_sck_idle_high: assert property (!busy |-> sck)
    else $error("serial clock low while master idle");
  a_sck_low_half: assert property ($fell(sck) |-> !sck [*4] ##1 sck)
    else $error("serial clock low phase not four cycles");
  a_sck_high_half: assert property ($rose(sck) |-> sck [*4])
    else $error("serial clock high phase too short");
  a_word_len: assert property (done |-> rise_q == 4'h8)
    else $error("word ended after wrong number of clocks");
  a_rx_irq_end: assert property (rx_complete_irq |-> rise_q == 4'h8 || $past(done) || $past(done, 2))
    else $error("receive irq away from word end");
  a_sdo_at_sample: assert property ($rose(sck) |=> $stable(sdo) [*2])
    else $error("slave output moved near sample edge");
  a_sdi_at_sample: assert property ($rose(sck) |-> $stable(sdi))
    else $error("master data moved on sample edge");
  a_done_pulse: assert property (done |=> !done)
    else $error("word done longer than one cycle");
  a_tx_irq_pulse: assert property (tx_enable_irq |=> !tx_enable_irq)
    else $error("transmit irq longer than one cycle");

  c_two_words: cover property (done ##[1:80] done);
  c_rx_irq: cover property (rx_complete_irq);
  c_tx_irq: cover property (tx_enable_irq);
endmodule : csu_props

// ===== tb/csu_test.sv
// Bench joining the slave and master ends over one serial link
`timescale 1ns/1ps
`include "csu_regs.svh"
module csu_test;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic rx_complete_irq;
  logic tx_enable_irq;
  logic start = 1'b0;
  logic cont = 1'b0;
  logic [7:0] tx_word = 8'h00;
  logic busy;
  logic done;
  logic [7:0] rx_word;
  logic [7:0] w [4];
  logic [15:0] rd_v;
  int err_total = 0;
  int n_tests = 0;
  int n_rx = 0;
  int n_tx = 0;
  int r0;
  int t0;
  int cyc = 0;

  csu_if lnk ();
  csu_slave u_csu_slave (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_complete_irq(rx_complete_irq), .tx_enable_irq(tx_enable_irq), .link(lnk));
  csu_master u_csu_master (.core_clk(core_clk), .resetn(resetn), .start(start),
    .cont(cont), .tx_word(tx_word), .busy(busy), .done(done), .rx_word(rx_word),
    .link(lnk));
  csu_props u_csu_props (.core_clk(core_clk), .resetn(resetn), .sck(lnk.sck),
    .sdi(lnk.sdi), .sdo(lnk.sdo), .busy(busy), .done(done),
    .rx_complete_irq(rx_complete_irq), .tx_enable_irq(tx_enable_irq));

  always #50 core_clk = ~core_clk;

  task automatic end_sim();
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // Irq pulse counters and the hang limit
  always @(posedge core_clk)
  begin
    cyc++;
    if (rx_complete_irq === 1'b1)
      n_rx++;
    if (tx_enable_irq === 1'b1)
      n_tx++;
    if (cyc == 6000)
    begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    rd_v = reg_rdata;
  endtask : rd

  task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
    rd(a);
    chk(rd_v, exp);
  endtask : rchk

  // Waits for the master's word end, bounded
  task automatic wdone();
    int k;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (done !== 1'b1 && k < 200);
    chk(16'(k < 200), 16'h0001);
  endtask : wdone

  task automatic go(input logic [7:0] a, input logic [7:0] b, input logic c);
    @(posedge core_clk);
    start <= 1'b1;
    cont <= c;
    tx_word <= a;
    @(posedge core_clk);
    start <= 1'b0;
    tx_word <= b;
  endtask : go

  function automatic logic [15:0] st(input logic b, input logic o);
    return {8'h00, b, 6'h00, o};
  endfunction : st

  function automatic logic [7:0] pick(input int i, input logic [7:0] c);
    return (i == 0) ? c : 8'($urandom);
  endfunction : pick

  initial
  begin
    void'($urandom(32'h7b66));
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    rchk(`CSU_ADDR_CTL0, 16'h0000);
    rchk(3'h7, 16'h0000);
    wr(`CSU_ADDR_CTL1, 16'h0007);
    rchk(`CSU_ADDR_CTL1, 16'h0007);
    wr(`CSU_ADDR_CTL2, 16'h0000);
    rchk(`CSU_ADDR_CTL2, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      w[0] = pick(i, 8'h80);
      w[1] = pick(i, 8'h01);
      w[2] = pick(i, 8'hff);
      w[3] = pick(i, 8'h00);
      // Receive only: second word unread first word
      wr(`CSU_ADDR_CTL0, 16'h00a3);
      rchk(`CSU_ADDR_CTL0, 16'h00a3);
      r0 = n_rx;
      rd(`CSU_ADDR_RX);
      rchk(`CSU_ADDR_STAT, st(1'b1, 1'b0));
      go(w[0], w[1], 1'b1);
      wdone();
      cont <= 1'b0;
      wr(`CSU_ADDR_CTL0, 16'h00a2);
      wdone();
      repeat (8) @(posedge core_clk);
      chk(16'(n_rx - r0), 16'h0002);
      rchk(`CSU_ADDR_RX, {8'h00, w[1]});
      rchk(`CSU_ADDR_STAT, st(1'b0, 1'b1));
      wr(`CSU_ADDR_STAT, 16'h0000);
      rchk(`CSU_ADDR_STAT, st(1'b0, 1'b0));
      wr(`CSU_ADDR_CTL0, 16'h0000);
      // Transmit and receive, two words back to back
      wr(`CSU_ADDR_CTL0, 16'h00e3);
      t0 = n_tx;
      r0 = n_rx;
      wr(`CSU_ADDR_TX, {8'h00, w[2]});
      rchk(`CSU_ADDR_STAT, st(1'b1, 1'b0));
      repeat (3) @(posedge core_clk);
      chk(16'(n_tx - t0), 16'h0001);
      wr(`CSU_ADDR_TX, {8'h00, w[3]});
      go(w[0], w[1], 1'b1);
      wdone();
      cont <= 1'b0;
      chk({8'h00, rx_word}, {8'h00, w[2]});
      rchk(`CSU_ADDR_RX, {8'h00, w[0]});
      wdone();
      chk({8'h00, rx_word}, {8'h00, w[3]});
      repeat (8) @(posedge core_clk);
      chk(16'(n_tx - t0), 16'h0002);
      chk(16'(n_rx - r0), 16'h0002);
      rchk(`CSU_ADDR_RX, {8'h00, w[1]});
      rchk(`CSU_ADDR_STAT, st(1'b0, 1'b0));
      wr(`CSU_ADDR_CTL0, 16'h0000);
    end
    // Single transmit only; a write while busy is dropped
    wr(`CSU_ADDR_CTL0, 16'h00c0);
    t0 = n_tx;
    r0 = n_rx;
    wr(`CSU_ADDR_TX, 16'h005a);
    wr(`CSU_ADDR_TX, 16'h00a5);
    go(8'h3c, 8'h3c, 1'b0);
    wdone();
    chk({8'h00, rx_word}, 16'h005a);
    repeat (8) @(posedge core_clk);
    chk(16'(n_tx - t0), 16'h0000);
    chk(16'(n_rx - r0), 16'h0001);
    rchk(`CSU_ADDR_STAT, st(1'b0, 1'b0));
    rchk(`CSU_ADDR_TX, 16'h0000);
    end_sim();
  end
endmodule : csu_test
